// ### hw/mci_pkg.sv
// Constants, types and decode functions for the multiphase clock interleave block.
// Assumes a 100 MHz core clock and a free-running link sampling clock near 6 ns.
package mci_pkg;

  localparam int CORE_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 6;
  localparam int LINK_W         = 10;

  // High time and low time of one sync pulse slot
  localparam int SYNC_HALF_NS   = 80;
  localparam int SYNC_HALF_CYC  = (SYNC_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // Gap between selected edges that marks the omitted pulse
  localparam int MARKER_GAP_NS  = 240;
  localparam logic [LINK_W-1:0] MARKER_GAP_CYC = LINK_W'(MARKER_GAP_NS / LINK_PERIOD_NS);

  // Line held low this long means the system is off
  localparam int OFF_NS         = 1000;
  localparam logic [LINK_W-1:0] OFF_CYC = LINK_W'(OFF_NS / LINK_PERIOD_NS);

  localparam logic [1:0] SETTLE_CYC   = 2'h3;
  localparam logic [3:0] PULSES_SIX   = 4'h6;
  localparam logic [3:0] PULSES_EIGHT = 4'h8;
  localparam logic [3:0] LAST_IDX_SIX = 4'h4;
  localparam logic [1:0] LOCK_MARKS   = 2'h2;

  // Phase-select code: master sees resistor count, slave sees its tap
  typedef enum logic [1:0] {
    MCI_LVL_GND  = 2'b00,
    MCI_LVL_TAP1 = 2'b01,
    MCI_LVL_TAP2 = 2'b10,
    MCI_LVL_TAP3 = 2'b11
  } mci_level_t;

  typedef enum logic [1:0] {
    MCI_ST_SETTLE = 2'b00,
    MCI_ST_IDLE   = 2'b01,
    MCI_ST_RUN    = 2'b10
  } mci_core_st_t;

  typedef struct packed {
    logic       master;
    mci_level_t level;
    logic       rising;
  } mci_strap_t;

  typedef struct packed {
    logic       enable;
    logic       rt_high;
    mci_level_t code;
    logic       lim2_high;
  } mci_pins_t;

  // Sync pulses per switching period chosen from sensed slave positions
  function automatic logic [3:0] mci_pulses(input mci_level_t lvl);
    return (lvl == MCI_LVL_TAP2) ? PULSES_SIX : PULSES_EIGHT;
  endfunction : mci_pulses

  // Selected edges a slave waits after the period start
  function automatic logic [3:0] mci_slot_delay(input logic six, input mci_level_t lvl);
    logic [3:0] d;
    d = 4'h0;
    unique case (lvl)
      MCI_LVL_GND:  d = six ? 4'h1 : 4'h2;
      MCI_LVL_TAP1: d = six ? 4'h2 : 4'h1;
      MCI_LVL_TAP2: d = six ? 4'h0 : 4'h3;
      MCI_LVL_TAP3: d = 4'h0;
    endcase
    return d;
  endfunction : mci_slot_delay

endpackage : mci_pkg

// ### hw/mci_top.sv
// Multiphase clock interleave: sync clock master generator and slave phase locker.
// Assumes strap inputs are comparator levels, stable after reset, and the sync line
// wire level is resolved outside from o_sync_line_o / o_sync_line_oe.
`timescale 1ns/1ps

module mci_top
  import mci_pkg::*;
#(
  parameter int P_SYNC_HALF_CYC = SYNC_HALF_CYC
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_link_clk,
  input  wire logic       i_enable,
  input  wire logic       i_timing_resistor_high,
  input  wire logic [1:0] i_phase_select_code,
  input  wire logic       i_channel2_limit_pin,
  input  wire logic       i_sync_line_i,
  output logic            o_sync_line_o,
  output logic            o_sync_line_oe,
  output logic            o_phase_select_src_en,
  output logic            o_master,
  output logic            o_system_off,
  output logic [3:0]      o_pulses_per_period,
  output logic            o_ch1_pulse,
  output logic            o_ch2_pulse
);

  if (P_SYNC_HALF_CYC < 1 || P_SYNC_HALF_CYC > 255) begin : g_bad_half
    $error("P_SYNC_HALF_CYC must lie in 1..255");
  end

  localparam logic [7:0] HALF_LAST = 8'(P_SYNC_HALF_CYC - 1);

  // ---------------- Core domain ----------------
  mci_pins_t    pins_meta;
  mci_pins_t    pins;
  logic         off_meta, off_sync;
  logic         t1_meta, t1_sync, t1_prev;
  logic         t2_meta, t2_sync, t2_prev;
  logic         l_off, next_l_off;
  logic         l_t1, next_l_t1;
  logic         l_t2, next_l_t2;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pins_meta <= '0;
      pins      <= '0;
      off_meta  <= 1'b0;
      off_sync  <= 1'b0;
      t1_meta   <= 1'b0;
      t1_sync   <= 1'b0;
      t1_prev   <= 1'b0;
      t2_meta   <= 1'b0;
      t2_sync   <= 1'b0;
      t2_prev   <= 1'b0;
    end else begin
      pins_meta <= '{i_enable, i_timing_resistor_high, mci_level_t'(i_phase_select_code),
                     i_channel2_limit_pin};
      pins      <= pins_meta;
      off_meta  <= l_off;
      off_sync  <= off_meta;
      t1_meta   <= l_t1;
      t1_sync   <= t1_meta;
      t1_prev   <= t1_sync;
      t2_meta   <= l_t2;
      t2_sync   <= t2_meta;
      t2_prev   <= t2_sync;
    end
  end

  mci_core_st_t state, next_state;
  mci_strap_t   strap, next_strap;
  logic [1:0]   settle, next_settle;
  logic [7:0]   half, next_half;
  logic         high, next_high;
  logic [3:0]   slot, next_slot;
  logic         line, next_line;
  logic         line_oe, next_line_oe;
  logic         src_en, next_src_en;
  logic         ready, next_ready;
  logic [3:0]   ppp, next_ppp;
  logic         ch1, next_ch1;
  logic         ch2, next_ch2;
  logic [3:0]   npp;

  assign npp = mci_pulses(strap.level);

  always_comb begin
    next_state   = state;
    next_strap   = strap;
    next_settle  = settle;
    next_half    = half;
    next_high    = high;
    next_slot    = slot;
    next_line    = 1'b0;
    next_ch1     = 1'b0;
    next_ch2     = 1'b0;
    next_ready   = ready;
    unique case (state)
      MCI_ST_SETTLE: begin
        next_settle = settle + 2'h1;
        if (settle == SETTLE_CYC) begin
          next_strap.master = !pins.rt_high;
          next_strap.level  = pins.code;
          next_strap.rising = pins.lim2_high;
          next_ready        = 1'b1;
          next_state        = MCI_ST_IDLE;
        end
      end
      MCI_ST_IDLE: begin
        next_half = 8'h0;
        next_high = 1'b1;
        next_slot = 4'h0;
        if (pins.enable) begin
          next_state = MCI_ST_RUN;
          next_line  = 1'b1;
        end
      end
      MCI_ST_RUN: begin
        if (!pins.enable) begin
          next_state = MCI_ST_IDLE;
        end else begin
          if (half == HALF_LAST) begin
            next_half = 8'h0;
            next_high = !high;
            if (high) begin
              next_ch1 = strap.master && slot == 4'h0;
              next_ch2 = strap.master && slot == (npp >> 1);
            end else begin
              next_slot = (slot == npp - 4'h1) ? 4'h0 : slot + 4'h1;
            end
          end else begin
            next_half = half + 8'h1;
          end
          // Last slot stays low so slaves find the period start
          next_line = next_high && next_slot != npp - 4'h1;
        end
      end
      default: next_state = MCI_ST_SETTLE;
    endcase
    if (!strap.master && state == MCI_ST_RUN && !off_sync) begin
      next_ch1 = t1_sync != t1_prev;
      next_ch2 = t2_sync != t2_prev;
    end
    next_line_oe = strap.master && next_state == MCI_ST_RUN;
    next_src_en  = next_strap.master && next_ready;
    next_ppp     = next_strap.master ? mci_pulses(next_strap.level) : 4'h0;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state   <= MCI_ST_SETTLE;
      strap   <= '0;
      settle  <= 2'h0;
      half    <= 8'h0;
      high    <= 1'b1;
      slot    <= 4'h0;
      line    <= 1'b0;
      line_oe <= 1'b0;
      src_en  <= 1'b0;
      ready   <= 1'b0;
      ppp     <= 4'h0;
      ch1     <= 1'b0;
      ch2     <= 1'b0;
    end else begin
      state   <= next_state;
      strap   <= next_strap;
      settle  <= next_settle;
      half    <= next_half;
      high    <= next_high;
      slot    <= next_slot;
      line    <= next_line;
      line_oe <= next_line_oe;
      src_en  <= next_src_en;
      ready   <= next_ready;
      ppp     <= next_ppp;
      ch1     <= next_ch1;
      ch2     <= next_ch2;
    end
  end

  assign o_sync_line_o         = line;
  assign o_sync_line_oe        = line_oe;
  assign o_phase_select_src_en = src_en;
  assign o_master              = strap.master;
  assign o_system_off          = !strap.master && off_sync;
  assign o_pulses_per_period   = ppp;
  assign o_ch1_pulse           = ch1;
  assign o_ch2_pulse           = ch2;

  // ---------------- Link domain ----------------
  logic              l_rdy_meta, l_rdy_sync;
  logic              l_line_meta, l_line_sync;

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      l_rdy_meta  <= 1'b0;
      l_rdy_sync  <= 1'b0;
      l_line_meta <= 1'b0;
      l_line_sync <= 1'b0;
    end else begin
      l_rdy_meta  <= ready;
      l_rdy_sync  <= l_rdy_meta;
      l_line_meta <= i_sync_line_i;
      l_line_sync <= l_line_meta;
    end
  end

  mci_strap_t        l_cfg, next_l_cfg;
  logic              l_cfg_ok, next_l_cfg_ok;
  logic              l_prev, next_l_prev;
  logic [LINK_W-1:0] l_gap, next_l_gap;
  logic [LINK_W-1:0] l_per, next_l_per;
  logic [LINK_W-1:0] l_plen, next_l_plen;
  logic [LINK_W-1:0] l_low, next_l_low;
  logic [LINK_W-1:0] l_timer, next_l_timer;
  logic [3:0]        l_idx, next_l_idx;
  logic              l_six, next_l_six;
  logic [1:0]        l_seen, next_l_seen;
  logic              ev, marker, fire1;
  logic [3:0]        cur_idx;

  function automatic logic [LINK_W-1:0] sat_inc(input logic [LINK_W-1:0] v);
    return (v == '1) ? v : v + LINK_W'(1);
  endfunction : sat_inc

  always_comb begin
    next_l_cfg    = l_cfg;
    next_l_cfg_ok = l_cfg_ok;
    if (l_rdy_sync && !l_cfg_ok) begin
      next_l_cfg    = strap;      // Stable since ready rose
      next_l_cfg_ok = 1'b1;
    end
    next_l_prev = l_line_sync;
    ev = l_cfg.rising ? (l_line_sync && !l_prev) : (!l_line_sync && l_prev);
    marker  = ev && l_gap > MARKER_GAP_CYC;
    cur_idx = marker ? 4'h0 : l_idx + 4'h1;
    next_l_gap  = ev ? '0 : sat_inc(l_gap);
    next_l_idx  = ev ? cur_idx : l_idx;
    next_l_per  = marker ? LINK_W'(1) : sat_inc(l_per);
    next_l_plen = marker ? l_per : l_plen;
    next_l_six  = marker ? (l_idx == LAST_IDX_SIX) : l_six;
    next_l_seen = (marker && l_seen != LOCK_MARKS) ? l_seen + 2'h1 : l_seen;
    next_l_low  = l_line_sync ? '0 : sat_inc(l_low);
    next_l_off  = l_low >= OFF_CYC;
    if (l_off) begin
      next_l_seen = 2'h0;
    end
    // Slot per tap, except MCI_LVL_TAP3 (always 0), depends on the six- or eight-pulse period seen at the last marker
    fire1 = l_cfg_ok && !l_cfg.master && l_seen == LOCK_MARKS && ev && !l_off
            && cur_idx == mci_slot_delay(l_six, l_cfg.level);
    next_l_timer = l_timer;
    if (fire1) begin
      next_l_timer = l_plen >> 1;
    end else if (l_timer != '0) begin
      next_l_timer = l_timer - LINK_W'(1);
    end
    next_l_t1 = l_t1 ^ fire1;
    next_l_t2 = l_t2 ^ (l_timer == LINK_W'(1));
  end

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      l_cfg    <= '0;
      l_cfg_ok <= 1'b0;
      l_prev   <= 1'b0;
      l_gap    <= '0;
      l_per    <= '0;
      l_plen   <= '0;
      l_low    <= '0;
      l_timer  <= '0;
      l_idx    <= 4'h0;
      l_six    <= 1'b0;
      l_seen   <= 2'h0;
      l_off    <= 1'b0;
      l_t1     <= 1'b0;
      l_t2     <= 1'b0;
    end else begin
      l_cfg    <= next_l_cfg;
      l_cfg_ok <= next_l_cfg_ok;
      l_prev   <= next_l_prev;
      l_gap    <= next_l_gap;
      l_per    <= next_l_per;
      l_plen   <= next_l_plen;
      l_low    <= next_l_low;
      l_timer  <= next_l_timer;
      l_idx    <= next_l_idx;
      l_six    <= next_l_six;
      l_seen   <= next_l_seen;
      l_off    <= next_l_off;
      l_t1     <= next_l_t1;
      l_t2     <= next_l_t2;
    end
  end

endmodule : mci_top

// ### tb/mci_top_assertions.sv
// Checker on the core-domain ports of mci_top.
// Assumes the default sync half width of eight core cycles.
`timescale 1ns/1ps
module mci_top_assertions #(
  parameter int P_SYNC_HALF_CYC = 8
) (
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic       i_enable,
  input wire logic [1:0] i_phase_select_code,
  input wire logic       o_sync_line_o,
  input wire logic       o_sync_line_oe,
  input wire logic       o_phase_select_src_en,
  input wire logic       o_master,
  input wire logic       o_system_off,
  input wire logic [3:0] o_pulses_per_period,
  input wire logic       o_ch1_pulse,
  input wire logic       o_ch2_pulse
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  chk_src_en_role: assert property (o_phase_select_src_en == o_master)
    else $error("source enable differs from role");
  chk_ppp_master: assert property (o_master |->
    o_pulses_per_period == ((i_phase_select_code == 2'h2) ? 4'h6 : 4'h8))
    else $error("master pulse count wrong");
  chk_ppp_slave: assert property (!o_master |-> o_pulses_per_period == 4'h0)
    else $error("slave reports pulse count");
  chk_oe_role: assert property (o_sync_line_oe |-> o_master)
    else $error("slave drives sync line");
  chk_ch1_at_fall: assert property (o_master && o_ch1_pulse |-> $fell(o_sync_line_o))
    else $error("master ch1 not at line fall");
  chk_half_eight: assert property (o_master && o_ch1_pulse && o_pulses_per_period == 4'h8
    |-> ##64 o_ch2_pulse)
    else $error("ch2 not half period after ch1");
  chk_half_six: assert property (o_master && o_ch1_pulse && o_pulses_per_period == 4'h6
    |-> ##48 o_ch2_pulse)
    else $error("six-pulse ch2 spacing wrong");
  chk_high_time: assert property ($rose(o_sync_line_o) |->
    o_sync_line_o[*8] ##1 !o_sync_line_o)
    else $error("sync pulse high time wrong");
  chk_release: assert property (!i_enable[*6] |-> !o_sync_line_oe)
    else $error("line not released when stopped");
  chk_off_quiet: assert property (o_system_off |-> !o_ch1_pulse && !o_ch2_pulse && !o_master)
    else $error("activity while system off");
endmodule : mci_top_assertions

bind mci_top mci_top_assertions #(.P_SYNC_HALF_CYC(P_SYNC_HALF_CYC)) chk_u (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_enable(i_enable),
  .i_phase_select_code(i_phase_select_code), .o_sync_line_o(o_sync_line_o),
  .o_sync_line_oe(o_sync_line_oe), .o_phase_select_src_en(o_phase_select_src_en),
  .o_master(o_master), .o_system_off(o_system_off),
  .o_pulses_per_period(o_pulses_per_period), .o_ch1_pulse(o_ch1_pulse),
  .o_ch2_pulse(o_ch2_pulse));

// ### tb/mci_sync_partner.sv
// Far-side clock master driving the shared sync line.
// Assumes the bench resolves the released wire through a pull-down.
`timescale 1ns/1ps
module mci_sync_partner (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_run,
  input  wire logic i_six,
  output logic      o_line,
  output logic      o_oe,
  output logic      o_start
);
  logic [7:0] cnt;
  logic [7:0] plen;
  assign plen = i_six ? 8'h60 : 8'h80;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 8'h0;
      o_line <= 1'b0;
      o_oe <= 1'b0;
      o_start <= 1'b0;
    end else begin
      o_oe <= i_run;
      cnt <= (!i_run || cnt == plen - 8'h1) ? 8'h0 : cnt + 8'h1;
      o_start <= i_run && cnt == 8'h0;
      // Last slot stays low to mark the period start
      o_line <= i_run && cnt < plen - 8'h10 && !cnt[3];
    end
  end
endmodule : mci_sync_partner

// ### tb/mci_top_tb.sv
// Self-checking bench for mci_top as clock master and as slave.
// Assumes a pull-down on the sync line and a free-running link clock.
`timescale 1ns/1ps
module mci_top_tb;
  import mci_pkg::*;
  logic       i_core_clk, i_rstn, i_link_clk, i_enable, i_timing_resistor_high;
  logic [1:0] i_phase_select_code;
  logic       i_channel2_limit_pin, o_sync_line_o, o_sync_line_oe, o_phase_select_src_en;
  logic       o_master, o_system_off, o_ch1_pulse, o_ch2_pulse;
  logic [3:0] o_pulses_per_period;
  logic       p_run, p_six, p_line, p_oe, p_start;
  wire        sync_line = o_sync_line_oe ? o_sync_line_o : (p_oe ? p_line : 1'b0);
  int         miscompares = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         seed = 32'h6a696b45;
  int         c, n, base, t0, t1, t2;

  mci_top dut_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk),
    .i_enable(i_enable), .i_timing_resistor_high(i_timing_resistor_high),
    .i_phase_select_code(i_phase_select_code), .i_channel2_limit_pin(i_channel2_limit_pin),
    .i_sync_line_i(sync_line), .o_sync_line_o(o_sync_line_o), .o_sync_line_oe(o_sync_line_oe),
    .o_phase_select_src_en(o_phase_select_src_en), .o_master(o_master),
    .o_system_off(o_system_off), .o_pulses_per_period(o_pulses_per_period),
    .o_ch1_pulse(o_ch1_pulse), .o_ch2_pulse(o_ch2_pulse));
  mci_sync_partner partner_u (.i_clk(i_core_clk), .i_rstn(i_rstn), .i_run(p_run),
    .i_six(p_six), .o_line(p_line), .o_oe(p_oe), .o_start(p_start));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #1.3;
    forever #3 i_link_clk = ~i_link_clk;
  end

  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Waits for ch1 (0), ch2 (1) or partner period start (2); -1 if none
  task automatic wait_sig(input int which, output int t);
    t = -1;
    for (int k = 0; k < 400; k++) begin
      @(posedge i_core_clk);
      if ((which == 0 && o_ch1_pulse === 1'b1) || (which == 1 && o_ch2_pulse === 1'b1) ||
          (which == 2 && p_start === 1'b1)) begin
        t = cyc;
        break;
      end
    end
  endtask : wait_sig

  task automatic start(input logic mst, input logic [1:0] code, input logic lim2);
    i_rstn <= 1'b0;
    i_enable <= 1'b0;
    p_run <= 1'b0;
    i_timing_resistor_high <= ~mst;
    i_phase_select_code <= code;
    i_channel2_limit_pin <= lim2;
    repeat (16) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (($random(seed) & 32'h1f) + 8) @(posedge i_core_clk);
    i_enable <= 1'b1;
  endtask : start

  function automatic int exp_angle(input logic six, input logic [1:0] tap);
    case (tap)
      2'h0: return six ? 60 : 90;
      2'h1: return six ? 120 : 45;
      2'h2: return six ? 0 : 135;
      default: return 0;
    endcase
  endfunction : exp_angle

  initial begin
    i_rstn = 1'b0;
    i_enable = 1'b0;
    i_timing_resistor_high = 1'b0;
    i_phase_select_code = 2'h0;
    i_channel2_limit_pin = 1'b1;
    p_run = 1'b0;
    p_six = 1'b0;
    @(posedge i_core_clk);
    for (c = 0; c < 4; c++) begin
      start(1'b1, c[1:0], 1'($random(seed)));
      n = (c == 2) ? 6 : 8;
      repeat (40) @(posedge i_core_clk);
      check({12'h0, o_pulses_per_period}, 16'(n));
      check({15'h0, o_phase_select_src_en}, 16'h1);
      check({14'h0, o_master, o_system_off}, 16'h2);
      wait_sig(1, t0);
      wait_sig(0, t1);
      wait_sig(1, t2);
      check(16'(t2 - t1), 16'(n * 8));
      check(16'(t2 - t0), 16'(n * 16));
      i_enable <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      check({15'h0, sync_line}, 16'h0);
    end
    for (c = 0; c < 16; c++) begin
      p_six <= c[3];
      start(1'b0, c[1:0], c[2]);
      p_run <= 1'b1;
      n = c[3] ? 6 : 8;
      repeat (600) @(posedge i_core_clk);
      check({9'h0, o_system_off, o_master, o_phase_select_src_en, o_pulses_per_period}, 16'h0);
      wait_sig(2, t0);
      wait_sig(0, t1);
      wait_sig(1, t2);
      base = exp_angle(c[3], c[1:0]) * n / 360 * 16 + (c[2] ? 0 : 8);
      check(16'(t1 - t0 > base && t1 - t0 <= base + 10), 16'h1);
      check(16'(t2 - t1 >= n * 8 - 2 && t2 - t1 <= n * 8 + 2), 16'h1);
    end
    p_run <= 1'b0;
    repeat (300) @(posedge i_core_clk);
    check({15'h0, o_system_off}, 16'h1);
    wait_sig(0, t1);
    check(16'(t1), 16'hffff);
    end_sim();
  end
endmodule : mci_top_tb
